/* File: core/interrupt_vector_flags.v */
// Interrupt vector selection and pending-source flags, Wishbone slave.
// Also holds a sticky event status, its mask and one level interrupt.
// Register addresses and vector codes live in the defs header.
// Assumes sources give one-cycle request pulses and the CPU core clears
// a flag by pulsing its acknowledge when that source is serviced.
// Assumes every input is synchronous to clk; nothing here resynchronises.
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`include "intvec_defs.vh"

module interrupt_vector_flags
(
    input wire clk, // System clock, 10 MHz
    input wire rst_b, // Asynchronous reset, active low
    input wire [15:0] wb_adr_i, // Wishbone byte address
    input wire [7:0] wb_dat_i, // Wishbone write data
    output reg [7:0] wb_dat_o, // Wishbone read data
    input wire wb_we_i, // Wishbone write enable
    input wire wb_sel_i, // Wishbone byte select
    input wire wb_cyc_i, // Wishbone cycle
    input wire wb_stb_i, // Wishbone strobe
    output reg wb_ack_o, // Wishbone acknowledge
    input wire ext_pin_req, // External pin request pulse
    input wire software_trap_req, // Software trap request pulse
    input wire counter_chan0_req, // Counter channel 0 request pulse
    input wire counter_chan1_req, // Counter channel 1 request pulse
    input wire counter_overflow_req, // Counter overflow request pulse
    input wire keypad_req, // Keypad request pulse
    input wire conversion_done_req, // Conversion complete request pulse
    input wire [22:16] spare_req, // Unused source request pulses
    input wire [22:1] service_ack, // Pulse clears the serviced source flag
    input wire swtrap_ack, // Pulse clears the software trap request
    output reg [15:0] vector_addr, // Address of the winning vector pair
    output reg vector_valid, // A vectored source or reset is pending; spare flags alone leave it low
    output reg irq_o // Level interrupt, any unmasked status bit
);

    // Pending flags, trap request and the one-shot reset offer
    reg [22:1] pending_reg;
    reg [22:1] pending_next;
    reg swtrap_reg;
    reg reset_seen_reg;
    // Sticky event status and its mask, same bit layout
    reg [6:0] status_reg;
    reg [6:0] status_next;
    reg [6:0] mask_reg;
    // Combinational vector choice and read data
    reg [15:0] vec_next;
    reg [7:0] rd_data;
    // Request and event maps, bus decode
    wire [22:1] req_vec;
    wire [6:0] events;
    wire wb_req;
    wire wr_mask;
    wire rd_status;

    // Bus decode; ack low is required so a held request is taken only once
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_mask = wb_req & wb_we_i & wb_sel_i & (wb_adr_i == `ADDR_IRQ_MASK);
    assign rd_status = wb_req & ~wb_we_i & (wb_adr_i == `ADDR_IRQ_STATUS);

    // Map request pulses onto flag positions; unused positions stay zero
    assign req_vec = {
        spare_req, // Positions 22..16, flag only
        conversion_done_req, // Position 15
        keypad_req, // Position 14
        8'h00, // Positions 13..6 have no source
        counter_overflow_req, // Position 5
        counter_chan1_req, // Position 4
        counter_chan0_req, // Position 3
        1'b0, // Position 2 has no source
        ext_pin_req // Position 1
    };

    // Event map for the sticky status; the trap has no flag position
    assign events = {
        conversion_done_req, // Bit 6
        keypad_req, // Bit 5
        counter_overflow_req, // Bit 4
        counter_chan1_req, // Bit 3
        counter_chan0_req, // Bit 2
        ext_pin_req, // Bit 1
        software_trap_req // Bit 0
    };

    // Pending flags: a new request wins over a same-cycle acknowledge
    // Acks for positions with no source are harmless
    always @*
    begin
        pending_next = (pending_reg & ~service_ack) | req_vec;
    end

    // Flag, trap and reset-offer registers
    // The trap is held apart because it owns no flag position
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pending_reg <= {22{1'b0}};
            swtrap_reg <= 1'b0;
            reset_seen_reg <= 1'b0;
        end
        else
        begin
            pending_reg <= pending_next;
            // Trap request: set wins over the CPU core's clear
            swtrap_reg <= (swtrap_reg & ~swtrap_ack) | software_trap_req;
            reset_seen_reg <= 1'b1; // Reset vector is offered for one cycle
        end
    end

    // Fixed priority: higher vector address always wins
    // Reset outranks everything; spare flags never produce a vector, so a
    // lone spare flag leaves the output at the no-vector code
    always @*
    begin
        if (!reset_seen_reg)
            vec_next = `VEC_RESET;
        else if (swtrap_reg)
            vec_next = `VEC_SWTRAP;
        else if (pending_reg[`POS_EXTPIN])
            vec_next = `VEC_EXTPIN;
        else if (pending_reg[`POS_CHAN0])
            vec_next = `VEC_CHAN0;
        else if (pending_reg[`POS_CHAN1])
            vec_next = `VEC_CHAN1;
        else if (pending_reg[`POS_OVF])
            vec_next = `VEC_OVF;
        else if (pending_reg[`POS_KEYPAD])
            vec_next = `VEC_KEYPAD;
        else if (pending_reg[`POS_CONV])
            vec_next = `VEC_CONV;
        else
            vec_next = `VEC_NONE; // Spare sources 16..22 have no vector
    end

    // Registered vector outputs, one cycle behind the flags
    // Costs a cycle of latency but keeps the outputs straight from flops
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Reset vector stands, and is valid, while reset is held
            vector_addr <= `VEC_RESET;
            vector_valid <= 1'b1;
        end
        else
        begin
            // Valid is derived from the chosen code, never from the flags
            vector_addr <= vec_next;
            vector_valid <= (vec_next != `VEC_NONE);
        end
    end

    // Sticky status; set wins over the clear by read
    // Clear is applied first so an event in the read cycle survives
    always @*
    begin
        status_next = status_reg;
        if (rd_status)
            status_next = 7'h00;
        status_next = status_next | events;
    end

    // Status, mask and interrupt; irq follows the next status value
    // so a read that clears the status drops irq at the same edge
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            status_reg <= 7'h00;
            mask_reg <= `MASK_RESET;
            irq_o <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            // Only the mask is writable; every other address ignores writes
            if (wr_mask)
                mask_reg <= wb_dat_i[6:0];
            irq_o <= |(status_next & mask_reg);
        end
    end

    // Read mux; flag registers ignore writes, unmapped reads give zero
    // Flag bit 2 and positions 13..6 have no source and read zero
    // Pending flags read live, so a read never disturbs them
    always @*
    begin
        case (wb_adr_i)
            `ADDR_PENDING_LOW: rd_data = {pending_reg[6:1], 2'b00};
            `ADDR_PENDING_MID: rd_data = pending_reg[14:7];
            `ADDR_PENDING_HIGH: rd_data = pending_reg[22:15];
            `ADDR_IRQ_STATUS: rd_data = {1'b0, status_reg};
            `ADDR_IRQ_MASK: rd_data = {1'b0, mask_reg};
            `ADDR_VECTOR: rd_data = vector_addr[7:0];
            default: rd_data = 8'h00;
        endcase
    end

    // Single-wait-state ack; ack drops the cycle after it is given
    // Read data is zeroed outside ack so a shared bus can OR slaves
    // Back-to-back requests cost one idle cycle, as ack gates wb_req
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end
        else
        begin
            // Ack for every request, mapped or not, so no master can hang
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_data : 8'h00;
        end
    end

endmodule

/* File: include/intvec_defs.vh */
// Constants for the interrupt vector and pending-flag block.
// Included by core/interrupt_vector_flags.v only.
`ifndef INTVEC_DEFS_VH
`define INTVEC_DEFS_VH

// Register byte addresses
`define ADDR_PENDING_HIGH 16'hfe06
`define ADDR_PENDING_LOW 16'hfe04
`define ADDR_PENDING_MID 16'hfe05
`define ADDR_IRQ_STATUS 16'hfe10
`define ADDR_IRQ_MASK 16'hfe11
`define ADDR_VECTOR 16'hfe12

// Reset values
`define PENDING_RESET 8'h00
`define MASK_RESET 7'h00

// Vector addresses (first byte of each pair)
`define VEC_RESET 16'hfffe
`define VEC_SWTRAP 16'hfffc
`define VEC_EXTPIN 16'hfffa
`define VEC_CHAN0 16'hfff6
`define VEC_CHAN1 16'hfff4
`define VEC_OVF 16'hfff2
`define VEC_KEYPAD 16'hffe0
`define VEC_CONV 16'hffde
`define VEC_NONE 16'h0000

// Source flag positions in the 22-bit pending vector
`define POS_EXTPIN 1
`define POS_CHAN0 3
`define POS_CHAN1 4
`define POS_OVF 5
`define POS_KEYPAD 14
`define POS_CONV 15

// Status/mask bit layout for the interrupt output
`define EV_SWTRAP 0
`define EV_EXTPIN 1
`define EV_CHAN0 2
`define EV_CHAN1 3
`define EV_OVF 4
`define EV_KEYPAD 5
`define EV_CONV 6

`endif

/* File: bench/interrupt_vector_flags_props.sv */
// Port checker for interrupt_vector_flags.
// Sees only top-level ports; reset is async, active low.
`timescale 1ns/1ps
module ivf_props (
    input wire clk, input wire rst_b, input wire wb_cyc_i, input wire wb_stb_i,
    input wire wb_ack_o, input wire [7:0] wb_dat_o, input wire ext_pin_req,
    input wire software_trap_req, input wire counter_chan0_req, input wire keypad_req,
    input wire [15:0] vector_addr, input wire vector_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Bus handshake, then vector ranking two edges after a request
    ack_late_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 8'h00)
        else $error("read data outside ack");
    valid_match_a: assert property (vector_valid == (vector_addr != 16'h0000))
        else $error("valid disagrees with vector");
    trap_vector_a: assert property (software_trap_req |-> ##2 vector_addr == 16'hfffc)
        else $error("trap vector wrong");
    pin_rank_a: assert property (ext_pin_req |-> ##2 vector_addr >= 16'hfffa)
        else $error("pin outranked");
    chan0_rank_a: assert property (counter_chan0_req |-> ##2 vector_addr >= 16'hfff6)
        else $error("channel 0 outranked");
    key_rank_a: assert property (keypad_req |-> ##2 vector_addr >= 16'hffe0)
        else $error("keypad outranked");
endmodule
bind interrupt_vector_flags ivf_props props_i (.*);

/* File: bench/cpu_vector_fetch.sv */
// Behavioural CPU core fetching vectors and acknowledging sources.
// Waits for the cleared flag to reach the vector before the next fetch.
`timescale 1ns/1ps
module cpu_vector_fetch (
    input wire clk, input wire rst_b, input wire [15:0] vector_addr,
    input wire vector_valid, input wire [3:0] stall,
    output reg [22:1] service_ack, output reg swtrap_ack,
    output reg fetched, output reg [15:0] fetch_addr
);
    reg [4:0] wait_reg;
    // Reset vector is never serviced, so it is skipped
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            {service_ack, swtrap_ack, fetched, fetch_addr, wait_reg} <= '0;
        else
        begin
            {service_ack, swtrap_ack, fetched} <= '0;
            if (wait_reg != 5'h00)
                wait_reg <= wait_reg - 5'h01;
            else if (vector_valid && vector_addr != 16'hfffe)
            begin
                fetched <= 1'b1;
                fetch_addr <= vector_addr;
                wait_reg <= {1'b0, stall} + 5'h03;
                swtrap_ack <= vector_addr == 16'hfffc;
                service_ack[1] <= vector_addr == 16'hfffa;
                service_ack[3] <= vector_addr == 16'hfff6;
                service_ack[4] <= vector_addr == 16'hfff4;
                service_ack[5] <= vector_addr == 16'hfff2;
                service_ack[14] <= vector_addr == 16'hffe0;
                service_ack[15] <= vector_addr == 16'hffde;
            end
        end
    end
endmodule

/* File: bench/tb_interrupt_vector_flags.sv */
// Self-checking bench for interrupt_vector_flags with a CPU fetch model.
// One 10 MHz clock; expectations queued by the driver, matched by a monitor.
`timescale 1ns/1ps
module tb_interrupt_vector_flags;
    reg clk, rst_b, cyc, stb, we;
    reg [15:0] adr;
    reg [7:0] dat;
    reg [6:0] src, spare;
    reg [3:0] stall;
    reg [31:0] r;
    wire [7:0] dat_o;
    wire ack, irq, valid, fetched, swack;
    wire [15:0] vaddr, faddr;
    wire [22:1] sack;
    integer n_mismatch, tests_run, cycles, i, k;
    logic [15:0] vq[$];
    logic [7:0] rq[$];
    logic [15:0] vt[7] = '{16'hfffc, 16'hfffa, 16'hfff6, 16'hfff4, 16'hfff2, 16'hffe0, 16'hffde};
    interrupt_vector_flags dut (.clk(clk), .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .ext_pin_req(src[5]), .software_trap_req(src[6]),
        .counter_chan0_req(src[4]), .counter_chan1_req(src[3]), .counter_overflow_req(src[2]),
        .keypad_req(src[1]), .conversion_done_req(src[0]), .spare_req(spare),
        .service_ack(sack), .swtrap_ack(swack), .vector_addr(vaddr), .vector_valid(valid),
        .irq_o(irq));
    cpu_vector_fetch cpu (.clk(clk), .rst_b(rst_b), .vector_addr(vaddr), .vector_valid(valid),
        .stall(stall), .service_ack(sack), .swtrap_ack(swack), .fetched(fetched),
        .fetch_addr(faddr));
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input [15:0] seen, input [15:0] exp, input [39:0] what);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("[ERR] %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_mismatch);
            if (n_mismatch == 0 && tests_run > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // Classic cycle: held until ack is sampled, then one idle cycle
    task wb(input [15:0] a, input w, input [7:0] d);
        begin
            {adr, we, dat, cyc, stb} <= {a, w, d, 2'b11};
            @(posedge clk);
            while (ack !== 1'b1)
                @(posedge clk);
            {cyc, stb} <= 2'b00;
            @(posedge clk);
        end
    endtask
    task rd(input [15:0] a, input [7:0] e);
        begin
            rq.push_back(e);
            wb(a, 1'b0, 8'h00);
        end
    endtask
    // One-cycle request pulses; fetch order follows fixed priority
    task fire(input [6:0] m, input [6:0] s);
        begin
            {src, spare} <= {m, s};
            for (k = 0; k < 7; k = k + 1)
                if (m[6 - k])
                    vq.push_back(vt[k]);
            @(posedge clk);
            {src, spare} <= 14'h0000;
        end
    endtask
    initial
    begin
        clk = 1'b0;
        forever
            #50 clk = ~clk;
    end
    // Monitor, plus a cycle ceiling against hangs
    always @(posedge clk)
    begin
        if (ack === 1'b1 && we === 1'b0)
            check({8'h00, dat_o}, {8'h00, rq.pop_front()}, "read");
        if (fetched === 1'b1)
            check(faddr, vq.pop_front(), "fetch");
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch = n_mismatch + 1;
            wrap_up;
        end
    end
    initial
    begin
        {rst_b, cyc, stb, we, adr, dat, src, spare, stall} = '0;
        {n_mismatch, tests_run, cycles} = '0;
        r = 32'h776b;
        repeat (6)
            @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(16'hfe06, 8'h00);
        rd(16'hfe07, 8'h00);
        r = lfsr(r);
        fire(7'h00, r[6:0]);
        wb(16'hfe06, 1'b1, r[15:8]);
        rd(16'hfe06, {r[6:0], 1'b0});
        for (i = 0; i < 4; i = i + 1)
        begin
            r = lfsr(r);
            stall <= r[3:0];
            fire(i == 0 ? 7'h7f : r[10:4], 7'h00);
            while (vq.size() != 0)
                @(posedge clk);
            repeat (4)
                @(posedge clk);
        end
        check({15'h0000, irq}, 16'h0000, "irq");
        wb(16'hfe11, 1'b1, {1'b1, r[21:16], 1'b1});
        @(posedge clk);
        check({15'h0000, irq}, 16'h0001, "irq");
        rd(16'hfe11, {1'b0, r[21:16], 1'b1});
        rd(16'hfe10, 8'h7f);
        @(posedge clk);
        check({15'h0000, irq}, 16'h0000, "irq");
        rd(16'hfe10, 8'h00);
        wrap_up;
    end
endmodule
